/* File: core/nvrw_ctrl.sv */
// Module: start/tracking control for nonvolatile program/erase and reads
`timescale 1ns/100ps
`default_nettype none
module nvrw_ctrl
  import nvrw_pkg::*;
#(
  parameter int PROG_CYCLES = NVRW_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic unlock_key_port_wr,
  input wire logic [7:0] unlock_key_port_wdata,
  output logic [7:0] ctrl_rdata,
  output logic program_enable_bit,
  output logic write_start_bit,
  output logic read_start_bit,
  output logic nvm_prog_start,
  output logic nvm_read_strobe
);

  // ****************************************************************
  // State
  // ****************************************************************
  nvrw_unlock_t ul_q;
  nvrw_unlock_t ul_d;
  nvrw_wr_state_t wr_q;
  nvrw_wr_state_t wr_d;
  logic pen_q;
  logic rd_q;
  logic rd_d;
  logic prog_start_q;
  logic prog_done;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire set_wr = ctrl_wr && ctrl_wdata[NVRW_BIT_WRITE_START];
  wire set_rd = ctrl_wr && ctrl_wdata[NVRW_BIT_READ_START];
  // Any other control write breaks the key sequence as well
  wire write_ok = set_wr && (ul_q == NVRW_UL_OPEN) && pen_q && (wr_q == NVRW_WR_IDLE);
  wire wr_busy = (wr_q == NVRW_WR_BUSY);

  // Unlock sequencer: 55h then AAh opens a one-shot window
  always_comb begin
    ul_d = ul_q;
    case (ul_q)
      NVRW_UL_IDLE: begin
        if (unlock_key_port_wr && unlock_key_port_wdata == NVRW_KEY_FIRST) ul_d = NVRW_UL_GOT55;
      end
      NVRW_UL_GOT55: begin
        if (unlock_key_port_wr) ul_d = (unlock_key_port_wdata == NVRW_KEY_SECOND) ? NVRW_UL_OPEN : NVRW_UL_IDLE;
        else if (ctrl_wr) ul_d = NVRW_UL_IDLE;
      end
      NVRW_UL_OPEN: begin
        // Window is consumed by the next control or key write
        if (ctrl_wr || unlock_key_port_wr) ul_d = NVRW_UL_IDLE;
      end
      default: ul_d = NVRW_UL_IDLE;
    endcase
  end

  // Write operation: idle until an honoured start, busy until timer done
  always_comb begin
    wr_d = wr_q;
    case (wr_q)
      NVRW_WR_IDLE: begin
        if (write_ok) wr_d = NVRW_WR_BUSY;
      end
      NVRW_WR_BUSY: begin
        if (prog_done) wr_d = NVRW_WR_IDLE;
      end
      default: wr_d = NVRW_WR_IDLE;
    endcase
  end

  // Read bit: set by software, dropped by hardware the next cycle
  assign rd_d = set_rd && !rd_q;

  nvrw_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(prog_start_q),
    .done(prog_done)
  );

  // Registers; zero writes never clear the start bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ul_q <= NVRW_UL_IDLE;
      wr_q <= NVRW_WR_IDLE;
      pen_q <= NVRW_RST_BIT;
      rd_q <= NVRW_RST_BIT;
      prog_start_q <= NVRW_RST_BIT;
    end else begin
      ul_q <= ul_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      prog_start_q <= write_ok;
      if (ctrl_wr) pen_q <= ctrl_wdata[NVRW_BIT_PROGRAM_ENABLE];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Write-start mirrors the busy state, so it reads zero when idle
  assign write_start_bit = wr_busy;
  assign read_start_bit = rd_q;
  assign program_enable_bit = pen_q;
  assign nvm_prog_start = prog_start_q;
  assign nvm_read_strobe = rd_q;
  assign ctrl_rdata = {5'h00, pen_q, wr_busy, rd_q};

endmodule
`default_nettype wire

/* File: pkg/nvrw_pkg.sv */
// Package: constants and types for the nonvolatile read/write control block
package nvrw_pkg;

  // ****************************************************************
  // Control bit positions
  // ****************************************************************
  localparam int NVRW_BIT_READ_START = 0;
  localparam int NVRW_BIT_WRITE_START = 1;
  localparam int NVRW_BIT_PROGRAM_ENABLE = 2;

  // ****************************************************************
  // Unlock key values
  // ****************************************************************
  localparam logic [7:0] NVRW_KEY_FIRST = 8'h55;
  localparam logic [7:0] NVRW_KEY_SECOND = 8'hAA;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic NVRW_RST_BIT = 1'b0;
  localparam int NVRW_CLK_MHZ = 25;
  // Self-timed program/erase duration, in microseconds
  localparam int NVRW_PROG_TIME_US = 2;
  localparam int NVRW_PROG_CYCLES = NVRW_PROG_TIME_US * NVRW_CLK_MHZ;
  localparam int NVRW_TIMER_W = 16;

  // Unlock sequencer states
  typedef enum logic [2:0] {
    NVRW_UL_IDLE = 3'b001,
    NVRW_UL_GOT55 = 3'b010,
    NVRW_UL_OPEN = 3'b100
  } nvrw_unlock_t;

  // Write operation states
  typedef enum logic [1:0] {
    NVRW_WR_IDLE = 2'b01,
    NVRW_WR_BUSY = 2'b10
  } nvrw_wr_state_t;

endpackage

/* File: core/nvrw_timer.sv */
// Module: self-timed program/erase duration counter
`timescale 1ns/100ps
`default_nettype none
module nvrw_timer
  import nvrw_pkg::*;
#(
  parameter int CYCLES = NVRW_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic done
);

  logic [NVRW_TIMER_W-1:0] cnt_q;
  logic [NVRW_TIMER_W-1:0] cnt_d;
  logic run_q;
  logic run_d;
  wire last = run_q && (cnt_q == NVRW_TIMER_W'(CYCLES - 1));

  // Count from start until the programmed duration has elapsed
  assign run_d = start ? 1'b1 : (last ? 1'b0 : run_q);
  assign cnt_d = start ? '0 : (run_q ? cnt_q + 1'b1 : cnt_q);
  assign done = last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

endmodule
`default_nettype wire

/* File: dv/nvrw_ctrl_sva.sv */
// Checker for the nonvolatile control block
`timescale 1ns/100ps
`default_nettype none
module nvrw_ctrl_sva #(parameter int PROG_CYCLES = 50) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic unlock_key_port_wr,
  input wire logic [7:0] unlock_key_port_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic program_enable_bit,
  input wire logic write_start_bit,
  input wire logic read_start_bit,
  input wire logic nvm_prog_start,
  input wire logic nvm_read_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Busy length
  // ****
  logic [15:0] n_q;
  // Counts busy cycles, since a repeat count cannot follow the parameter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) n_q <= 16'h0000;
    else n_q <= write_start_bit ? n_q + 16'h0001 : 16'h0000;
  end
  rd_set_a: assert property (ctrl_wr && ctrl_wdata[0] && !read_start_bit |=> read_start_bit) else $error("rd");
  rd_clear_a: assert property (read_start_bit |=> !read_start_bit) else $error("rd clr");
  rd_strobe_a: assert property (nvm_read_strobe == read_start_bit) else $error("strobe");
  wr_cause_a: assert property (nvm_prog_start |-> $past(ctrl_wr) && $past(ctrl_wdata[1])) else $error("go");
  wr_len_a: assert property ($fell(write_start_bit) |-> n_q == PROG_CYCLES + 1) else $error("len");
  wr_keep_a: assert property (write_start_bit && n_q < PROG_CYCLES |=> write_start_bit) else $error("clr");
  wr_lock_a: assert property (ctrl_wr && !program_enable_bit |=> !nvm_prog_start) else $error("pen");
  wr_busy_a: assert property (write_start_bit |=> !nvm_prog_start) else $error("busy");
  rd_view_a: assert property (ctrl_rdata[2:0] == {program_enable_bit, write_start_bit, read_start_bit})
    else $error("rdata");
endmodule
`default_nettype wire

/* File: dv/nvrw_ctrl_tb.sv */
// Testbench for the nonvolatile control block
`timescale 1ns/100ps
`default_nettype none
module nvrw_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_wr = 1'b0;
  logic unlock_key_port_wr = 1'b0;
  logic [7:0] d = 8'h00;
  logic [7:0] ctrl_rdata;
  logic pen, ws, rs, ps, rstb;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  nvrw_ctrl #(.PROG_CYCLES(8)) u_nvrw_ctrl (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(d),
    .unlock_key_port_wr(unlock_key_port_wr), .unlock_key_port_wdata(d), .ctrl_rdata(ctrl_rdata),
    .program_enable_bit(pen), .write_start_bit(ws), .read_start_bit(rs), .nvm_prog_start(ps), .nvm_read_strobe(rstb));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One idle cycle, then one strobe cycle, so no strobe is lowered and raised in one step
  task automatic wr(input logic k, input logic [7:0] v);
    @(negedge clk);
    ctrl_wr = !k;
    unlock_key_port_wr = k;
    d = v;
    @(negedge clk);
    ctrl_wr = 1'b0;
    unlock_key_port_wr = 1'b0;
  endtask
  task automatic stop_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_read;
    wr(0, 8'h01);
    chk({rstb, ctrl_rdata[6:0]}, 8'h81);
    @(negedge clk);
    chk(ctrl_rdata, 8'h00);
    $display("read done");
  endtask
  // Busy lasts nine cycles with eight timer cycles; extra writes land inside
  task automatic t_prog;
    wr(0, 8'h04);
    wr(1, 8'h55);
    wr(1, 8'hAA);
    wr(0, 8'h06);
    chk({ps, ctrl_rdata[6:0]}, 8'h86);
    chk({5'h00, pen, ws, rs}, 8'h06);
    wr(0, 8'h04);
    chk(ctrl_rdata, 8'h06);
    wr(1, 8'h55);
    wr(1, 8'hAA);
    wr(0, 8'h06);
    chk({ps, ctrl_rdata[6:0]}, 8'h06);
    @(negedge clk);
    chk(ctrl_rdata, 8'h04);
    $display("prog done");
  endtask
  task automatic t_lock;
    wr(0, 8'h06);
    chk(ctrl_rdata, 8'h04);
    wr(1, 8'hAA);
    wr(1, 8'h55);
    wr(0, 8'h06);
    chk(ctrl_rdata, 8'h04);
    wr(0, 8'h00);
    wr(1, 8'h55);
    wr(1, 8'hAA);
    wr(0, 8'h02);
    chk(ctrl_rdata, 8'h00);
    $display("lock done");
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 500) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    chk(ctrl_rdata, 8'h00);
    rst_n = 1'b1;
    @(negedge clk);
    t_read;
    t_prog;
    t_lock;
    stop_test;
  end
endmodule
bind nvrw_ctrl nvrw_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES)) u_nvrw_ctrl_sva (.*);
`default_nettype wire
